// File: hdl/tap_ctrl.sv
// Purpose: boundary-scan test access port controller with instruction and data registers
// Assumes: test clock pin sampled by sys_clk (25 MHz); test clock period well above 4 sys_clk
// Notes: rising and falling test clock edges are found after a two-stage synchroniser
//
// Function
// - idle holds on low, selects DR on high
// - select DR: low captures, high selects IR
// - capture DR loads chain pins for extest/sample
// - capture DR: high exit1, low shift
// - shift DR moves selected register toward output
// - shift DR stays low, exit1 on high
// - exit1 DR: high update, low pause
// - pause DR holds; high goes exit2
// - exit2 DR: high update, low shift
// - update DR latches chain on falling edge
// - chain parallel output changes only in update
// - other states hold shift stages and instruction
// - select IR: low captures, high resets
// - capture IR loads fixed pattern 01
// - capture IR: high exit1, low shift
// - shift IR moves instruction, exit on high
// - exit1 IR: high update, low pause
// - pause IR holds; high goes exit2
// - exit2 IR: high update, low shift
// - update IR latches instruction on falling edge
// - two-bit instruction, lsb first, four codes
// - reset state forces identification instruction
// - five high mode-select edges reach reset
`timescale 1ns/100ps
module tap_ctrl
  import tap_pkg::*;
#(
  parameter int CHAIN_LEN = TAP_CHAIN_LEN,
  parameter logic [31:0] ID_VALUE = TAP_ID_VALUE
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tdi_pin,
  output logic tdo_out,
  output logic tdo_oe,
  input wire logic [CHAIN_LEN-1:0] chain_pin_in,
  output logic [CHAIN_LEN-1:0] chain_par_out,
  output logic [1:0] cur_instr,
  output logic test_active,
  output logic extest_mode
);
  // ==========================================
  // pin synchronisers and edge detection
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_d_r;
  tap_sync u_sync_tck (.sys_clk(sys_clk), .rst_n(rst_n), .pin(tck_pin), .sync(tck_s));
  tap_sync u_sync_tms (.sys_clk(sys_clk), .rst_n(rst_n), .pin(tms_pin), .sync(tms_s));
  tap_sync u_sync_tdi (.sys_clk(sys_clk), .rst_n(rst_n), .pin(tdi_pin), .sync(tdi_s));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tck_s;
    end
  end

  wire tck_rise = tck_s & ~tck_d_r;
  wire tck_fall = ~tck_s & tck_d_r;

  // ==========================================
  // state register
  tap_state_t state_r;
  tap_state_t state_nxt;
  tap_next u_next (.cur(state_r), .tms(tms_s), .nxt(state_nxt));

  // tms-high walk ends in reset within five edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TAP_RESET;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================
  // decodes
  wire in_reset = (state_r == TAP_RESET);
  wire in_cap_dr = (state_r == TAP_CAP_DR);
  wire in_shift_dr = (state_r == TAP_SHIFT_DR);
  wire in_upd_dr = (state_r == TAP_UPD_DR);
  wire in_cap_ir = (state_r == TAP_CAP_IR);
  wire in_shift_ir = (state_r == TAP_SHIFT_IR);
  wire in_upd_ir = (state_r == TAP_UPD_IR);
  wire sel_chain = (cur_instr == TAP_IR_EXTEST) || (cur_instr == TAP_IR_SAMPLE);
  wire sel_ident = (cur_instr == TAP_IR_IDENT);
  wire sel_bypass = (cur_instr == TAP_IR_BYPASS);

  // ==========================================
  // instruction register
  logic [TAP_IR_W-1:0] ir_shift_r;
  logic [TAP_IR_W-1:0] ir_shift_nxt;
  // lsb out first, tdi enters msb
  assign ir_shift_nxt = in_cap_ir ? TAP_IR_CAPTURE :
                        in_shift_ir ? {tdi_s, ir_shift_r[TAP_IR_W-1:1]} : ir_shift_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_shift_r <= TAP_IR_CAPTURE;
    end else if (tck_rise) begin
      ir_shift_r <= ir_shift_nxt;
    end
  end

  // entering reset forces ident on the same edge, so no cycle shows reset with a stale instruction
  wire to_reset = tck_rise & (state_nxt == TAP_RESET);

  // latch on falling edge in update
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_instr <= TAP_IR_IDENT;
    end else if (in_reset || to_reset) begin
      cur_instr <= TAP_IR_IDENT;
    end else if (tck_fall && in_upd_ir) begin
      cur_instr <= ir_shift_r;
    end
  end

  // ==========================================
  // data registers
  logic [CHAIN_LEN-1:0] chain_r;
  logic [CHAIN_LEN-1:0] chain_nxt;
  logic [TAP_ID_W-1:0] id_r;
  logic [TAP_ID_W-1:0] id_nxt;
  logic bypass_r;
  logic bypass_nxt;
  wire chain_cap = in_cap_dr & sel_chain;
  wire chain_sh = in_shift_dr & sel_chain;
  assign chain_nxt = chain_cap ? chain_pin_in :
                     chain_sh ? {tdi_s, chain_r[CHAIN_LEN-1:1]} : chain_r;
  // identification loads its constant on capture; bypass captures zero
  assign id_nxt = (in_cap_dr & sel_ident) ? ID_VALUE :
                  (in_shift_dr & sel_ident) ? {tdi_s, id_r[TAP_ID_W-1:1]} : id_r;
  assign bypass_nxt = (in_cap_dr & sel_bypass) ? 1'b0 :
                      (in_shift_dr & sel_bypass) ? tdi_s : bypass_r;

  // data registers hold outside capture and shift
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_r <= '0;
      id_r <= '0;
      bypass_r <= 1'b0;
    end else if (tck_rise) begin
      chain_r <= chain_nxt;
      id_r <= id_nxt;
      bypass_r <= bypass_nxt;
    end
  end

  // parallel output only in update, falling edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_par_out <= '0;
    end else if (tck_fall && in_upd_dr && sel_chain) begin
      chain_par_out <= chain_r;
    end
  end

  // ==========================================
  // serial output
  wire dr_bit = sel_chain ? chain_r[0] : (sel_ident ? id_r[0] : bypass_r);
  wire tdo_sel = in_shift_ir ? ir_shift_r[0] : dr_bit;
  wire shifting = in_shift_dr | in_shift_ir;

  // drive on falling edge in shift states only
  // tester samples tdo on the next falling edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_out <= shifting ? tdo_sel : 1'b0;
      tdo_oe <= shifting;
    end
  end

  // test logic inactive in reset; extest hands pins to the chain output
  assign test_active = ~in_reset;
  assign extest_mode = ~in_reset & (cur_instr == TAP_IR_EXTEST);
endmodule

// File: hdl/tap_pkg.sv
// Purpose: shared constants and types for the boundary-scan tap controller
// Assumes: sys_clk at 25 MHz oversamples the test clock pin
// Notes: identification value is arbitrary
package tap_pkg;
  // ==========================================
  // instruction codes
  localparam int TAP_IR_W = 2;
  localparam logic [1:0] TAP_IR_EXTEST = 2'h0;
  localparam logic [1:0] TAP_IR_SAMPLE = 2'h1;
  localparam logic [1:0] TAP_IR_IDENT = 2'h2;
  localparam logic [1:0] TAP_IR_BYPASS = 2'h3;
  localparam logic [1:0] TAP_IR_CAPTURE = 2'h1;
  // ==========================================
  // register sizes, identification value and reset edge count
  localparam int TAP_CHAIN_LEN = 62;
  localparam int TAP_ID_W = 32;
  localparam logic [31:0] TAP_ID_VALUE = 32'h1234_5679;
  localparam int TAP_SYNC_STAGES = 2;
  localparam int TAP_RESET_TMS_EDGES = 5;
  // ==========================================
  // controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
    TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;
endpackage

// File: hdl/tap_sync.sv
// Purpose: two flip-flop synchroniser for one pin
// Assumes: asynchronous pin input
// Notes: first stage read only by second stage
`timescale 1ns/100ps
module tap_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic sync
);
  logic meta_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta_r <= pin;
      sync <= meta_r;
    end
  end
endmodule

// File: hdl/tap_next.sv
// Purpose: next-state function of the tap controller
// Assumes: evaluated at each rising test clock edge
// Notes: purely combinational
`timescale 1ns/100ps
module tap_next
  import tap_pkg::*;
(
  input tap_state_t cur,
  input wire logic tms,
  output tap_state_t nxt
);
  always_comb begin
    nxt = cur;
    unique case (cur)
      TAP_RESET: nxt = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: nxt = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nxt = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: nxt = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: nxt = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: nxt = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: nxt = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: nxt = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: nxt = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: nxt = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: nxt = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: nxt = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end
endmodule

// File: dv/tap_tester.sv
// Purpose: tester model driving the tap link pins
// Assumes: one tck period is 8 sys_clk (320 ns)
// Notes: tdo is seen as x while not driven
`timescale 1ns/100ps
module tap_tester (
  input wire logic sys_clk,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  output logic tck_pin,
  output logic tms_pin,
  output logic tdi_pin,
  output logic obs_valid,
  output logic obs_bit
);
  initial begin
    tck_pin = 1'b0;
    tms_pin = 1'b1;
    tdi_pin = 1'b0;
    obs_valid = 1'b0;
    obs_bit = 1'b0;
  end
  always @(posedge sys_clk) if (obs_valid) obs_valid <= 1'b0;
  // ==========
  // one tck cycle; tck stands low between steps
  // inputs held stable around the rise
  task automatic step(input logic m, input logic d, input logic samp);
    @(posedge sys_clk);
    tms_pin <= m;
    tdi_pin <= d;
    repeat (3) @(posedge sys_clk);
    tck_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    tck_pin <= 1'b0;
    obs_valid <= samp;
    obs_bit <= tdo_oe ? tdo_out : 1'bx;
  endtask
endmodule

// File: dv/tap_ctrl_checker.sv
// Purpose: port assertions for tap_ctrl
// Assumes: tck phases last several sys_clk
// Notes: pin edges found by plain sampling
`timescale 1ns/100ps
module tap_ctrl_checker #(parameter int CHAIN_LEN = 8) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tdi_pin,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  input wire logic [CHAIN_LEN-1:0] chain_pin_in,
  input wire logic [CHAIN_LEN-1:0] chain_par_out,
  input wire logic [1:0] cur_instr,
  input wire logic test_active,
  input wire logic extest_mode
);
  // ==========
  // edge helpers
  logic tck_r, tms_at_rise_r;
  logic [3:0] fall_age_r, hi_run_r, fall_age_nxt, hi_run_nxt;
  wire rise = tck_pin & ~tck_r;
  assign fall_age_nxt = (~tck_pin & tck_r) ? 4'h0 : fall_age_r + {3'h0, fall_age_r != 4'hf};
  assign hi_run_nxt = !rise ? hi_run_r : (tms_pin ? hi_run_r + {3'h0, hi_run_r != 4'h7} : 4'h0);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_r <= 1'b0;
      tms_at_rise_r <= 1'b1;
      fall_age_r <= 4'hf;
      hi_run_r <= 4'h0;
    end else begin
      tck_r <= tck_pin;
      tms_at_rise_r <= rise ? tms_pin : tms_at_rise_r;
      fall_age_r <= fall_age_nxt;
      hi_run_r <= hi_run_nxt;
    end
  end
  // ==========
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_after_fall;
    fall_age_r >= 4'h1 && fall_age_r <= 4'h8;
  endsequence
  sequence s_reach_reset;
    ##[1:8] !test_active;
  endsequence
  chk_reset_ident: assert property (!test_active |-> cur_instr == 2'h2)
    else $error("instruction not ident in reset state");
  chk_oe_idle: assert property (!test_active |-> !tdo_oe)
    else $error("tdo driven in reset state");
  chk_extest_flag: assert property (extest_mode == (test_active && cur_instr == 2'h0))
    else $error("extest flag wrong");
  chk_five_high: assert property ($rose(hi_run_r == 4'h5) |-> s_reach_reset)
    else $error("five high tms did not reach reset");
  chk_par_on_fall: assert property ($changed(chain_par_out) |-> s_after_fall)
    else $error("chain output moved off a falling edge");
  chk_instr_on_fall: assert property ($changed(cur_instr) && $past(test_active) && test_active |-> s_after_fall)
    else $error("instruction moved off a falling edge");
  chk_shift_entry: assert property ($rose(tdo_oe) |-> !tms_at_rise_r)
    else $error("shift entered with tms high");
  chk_shift_exit: assert property ($fell(tdo_oe) |-> (tms_at_rise_r) and s_after_fall)
    else $error("shift left with tms low");
endmodule
bind tap_ctrl tap_ctrl_checker #(.CHAIN_LEN(CHAIN_LEN)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .tck_pin(tck_pin), .tms_pin(tms_pin), .tdi_pin(tdi_pin), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
  .chain_pin_in(chain_pin_in), .chain_par_out(chain_par_out), .cur_instr(cur_instr),
  .test_active(test_active), .extest_mode(extest_mode));

// File: dv/test_tap_ctrl.sv
// Purpose: self-checking bench for tap_ctrl
// Assumes: tester model makes the link clock
// Notes: chain shortened to 8 stages
`timescale 1ns/100ps
module test_tap_ctrl;
  import tap_pkg::*;
  localparam int CL = 8;
  logic sys_clk = 1'b0;
  logic rst_n, tck_pin, tms_pin, tdi_pin, tdo_out, tdo_oe, test_active, extest_mode, obs_valid, obs_bit;
  logic [1:0] cur_instr;
  logic [CL-1:0] pins_r, chain_par_out, par_exp;
  logic [63:0] d;
  logic exp_q[$];
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  always #20 sys_clk = ~sys_clk;
  tap_ctrl #(.CHAIN_LEN(CL)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .tck_pin(tck_pin), .tms_pin(tms_pin),
    .tdi_pin(tdi_pin), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .chain_pin_in(pins_r), .chain_par_out(chain_par_out),
    .cur_instr(cur_instr), .test_active(test_active), .extest_mode(extest_mode));
  tap_tester u_tst (.sys_clk(sys_clk), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .tck_pin(tck_pin),
    .tms_pin(tms_pin), .tdi_pin(tdi_pin), .obs_valid(obs_valid), .obs_bit(obs_bit));
  // ==========
  // checking and closing
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (obs_valid) chk_val(64'(obs_bit), 64'(exp_q.pop_front()));
    if (cyc == 4000) begin
      err_total++;
      complete_run;
    end
  end
  // ==========
  // scan sequences; idle tdi is random
  task automatic st(input logic m);
    u_tst.step(m, 1'($urandom), 1'b0);
  endtask
  task automatic scan_ir(input logic [1:0] c, input logic p);
    logic [1:0] old;
    old = cur_instr;
    st(1'b1);
    st(1'b1);
    st(1'b0);
    st(1'b0);
    exp_q.push_back(1'b1);
    exp_q.push_back(1'b0);
    u_tst.step(1'b0, c[0], 1'b1);
    u_tst.step(1'b1, c[1], 1'b1);
    if (p) begin
      st(1'b0);
      st(1'b1);
    end
    chk_val(64'(cur_instr), 64'(old));
    st(1'b1);
    st(1'b0);
    chk_val(64'(cur_instr), 64'(c));
  endtask
  task automatic scan_dr(input int n, input logic [63:0] e);
    st(1'b1);
    st(1'b0);
    st(1'b0);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(e[i]);
      u_tst.step(i == n - 1, d[i], 1'b1);
    end
    chk_val(64'(chain_par_out), 64'(par_exp));
    st(1'b1);
    st(1'b0);
  endtask
  initial begin
    rst_n = 1'b0;
    pins_r = '0;
    par_exp = '0;
    d = {$urandom(59), $urandom};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk_val(64'(cur_instr), 64'(TAP_IR_IDENT));
    st(1'b0);
    st(1'b0);
    chk_val(64'(test_active), 64'h1);
    scan_dr(32, 64'(TAP_ID_VALUE));
    scan_ir(TAP_IR_SAMPLE, 1'b1);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) scan_ir(TAP_IR_EXTEST, 1'b0);
      chk_val(64'(extest_mode), 64'(k));
      pins_r <= CL'($urandom);
      d = {$urandom, $urandom};
      @(posedge sys_clk);
      scan_dr(CL, 64'(pins_r));
      par_exp = d[CL-1:0];
      chk_val(64'(chain_par_out), 64'(par_exp));
    end
    scan_ir(TAP_IR_BYPASS, 1'b1);
    d = {$urandom, $urandom};
    scan_dr(5, d << 1);
    st(1'b1);
    st(1'b0);
    st(1'b0);
    repeat (6) st(1'b1);
    chk_val(64'(test_active), 64'h0);
    chk_val(64'(cur_instr), 64'(TAP_IR_IDENT));
    complete_run;
  end
endmodule
